// ==== servo_status_outputs.sv ====
// Status outputs of a servo drive: in-position, ready, brake interlock, speed reached.
`timescale 1ns/1ps

module servo_status_outputs
    import servo_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic update,
    input servo_status_pkg::drive_state_type drive,
    input servo_status_pkg::status_cfg_type cfg,
    output logic in_position_flag,
    output logic in_position_valid,
    output logic ready_flag,
    output logic brake_interlock_out,
    output logic speed_reached_flag,
    output logic speed_reached_valid,
    output logic [servo_status_pkg::SLOT_N-1:0] slot_out,
    output logic [servo_status_pkg::SLOT_N-1:0] slot_used
);
    import servo_status_pkg::*;

    // ------------------------------------------------------------------
    // Combinational derivation
    // ------------------------------------------------------------------
    logic [DROOP_W-1:0] droop_abs;
    logic [SPEED_W-1:0] cmd_abs;
    logic [SPEED_W-1:0] err_abs;
    logic signed [SPEED_W:0] err_raw;
    logic servo_on_d_r;
    logic inp_nxt;
    logic sa_nxt;
    logic rd_nxt;
    logic db_nxt;

    // Magnitudes; the window is symmetric so sign does not matter.
    always_comb begin
        droop_abs = drive.droop[DROOP_W-1] ? DROOP_W'(-drive.droop) : drive.droop;
        cmd_abs = drive.speed_cmd[SPEED_W-1] ? SPEED_W'(-drive.speed_cmd) : drive.speed_cmd;
        err_raw = (SPEED_W+1)'(drive.speed_meas) - (SPEED_W+1)'(drive.speed_cmd);
        err_abs = err_raw[SPEED_W] ? SPEED_W'(-err_raw) : err_raw[SPEED_W-1:0];
    end

    // A wider window naturally keeps slow-rolling droop inside it.
    always_comb begin
        inp_nxt = 1'b0;
        if (drive.servo_on && !servo_on_d_r) begin
            inp_nxt = 1'b1;
        end else if (drive.servo_on) begin
            inp_nxt = (droop_abs <= cfg.position_window_param);
        end
    end

    // Speed reached logic; servo off wins over everything.
    always_comb begin
        sa_nxt = 1'b0;
        if (drive.servo_on) begin
            if (cmd_abs <= SPEED_LOW_LIMIT) begin
                sa_nxt = 1'b1;
            end else begin
                sa_nxt = (err_abs <= cfg.speed_tol);
            end
        end
    end

    assign rd_nxt = drive.servo_on && drive.able;
    assign db_nxt = !drive.brake_needed;

    // ------------------------------------------------------------------
    // Registered outputs, one update per control cycle
    // ------------------------------------------------------------------
    // Servo-on history for edge detection.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            servo_on_d_r <= 1'b0;
        end else if (clk_en && update) begin
            servo_on_d_r <= drive.servo_on;
        end
    end

    // Status levels hold between updates.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_position_flag <= 1'b0;
            ready_flag <= 1'b0;
            brake_interlock_out <= 1'b0;   // Safe default: braking applies until first update.
            speed_reached_flag <= 1'b0;
        end else if (clk_en && update) begin
            in_position_flag <= inp_nxt;
            ready_flag <= rd_nxt;
            brake_interlock_out <= db_nxt;
            speed_reached_flag <= sa_nxt;
        end
    end

    // Mode validity: a flag without meaning in the current loop is marked unusable.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_position_valid <= 1'b0;
            speed_reached_valid <= 1'b0;
        end else if (clk_en && update) begin
            in_position_valid <= (drive.mode != MODE_SPEED);
            speed_reached_valid <= (drive.mode != MODE_POSITION);
        end
    end

    // ------------------------------------------------------------------
    // Output assignment slots
    // ------------------------------------------------------------------
    // An unmapped or invalid selection leaves the slot low and unused.
    genvar g;
    generate
        for (g = 0; g < SLOT_N; g++) begin : gen_slot
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    slot_out[g] <= 1'b0;
                    slot_used[g] <= 1'b0;
                end else if (clk_en && update) begin
                    case (cfg.slot_sel[g])
                        SEL_READY: begin
                            slot_out[g] <= rd_nxt;
                            slot_used[g] <= 1'b1;
                        end
                        SEL_BRAKE: begin
                            slot_out[g] <= db_nxt;
                            slot_used[g] <= 1'b1;
                        end
                        SEL_SPEED: begin
                            slot_out[g] <= sa_nxt && (drive.mode != MODE_POSITION);
                            slot_used[g] <= (drive.mode != MODE_POSITION);
                        end
                        default: begin
                            slot_out[g] <= 1'b0;
                            slot_used[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ready_cause: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update) |=> (ready_flag == $past(drive.servo_on && drive.able)))
        else $error("ready flag does not follow servo-on and able");
    a_brake_inverse: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update) |=> (brake_interlock_out == !$past(drive.brake_needed)))
        else $error("brake interlock not inverse of brake need");
    a_speed_servo_off: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && !drive.servo_on) |=> !speed_reached_flag)
        else $error("speed reached set while servo off");
    a_speed_low_cmd: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.servo_on && cmd_abs <= SPEED_LOW_LIMIT) |=> speed_reached_flag)
        else $error("speed reached not forced at low command");
    a_speed_near: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.servo_on && cmd_abs > SPEED_LOW_LIMIT) |=>
        (speed_reached_flag == ($past(err_abs) <= $past(cfg.speed_tol))))
        else $error("speed reached disagrees with speed error");
    a_inp_servo_on: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.servo_on && !servo_on_d_r) |=> in_position_flag)
        else $error("in-position not set on servo-on");
    a_inp_window: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.servo_on && servo_on_d_r) |=>
        (in_position_flag == ($past(droop_abs) <= $past(cfg.position_window_param))))
        else $error("in-position disagrees with droop window");
    a_inp_mode: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.mode == MODE_SPEED) |=> !in_position_valid)
        else $error("in-position offered in speed loop");
    a_sa_mode: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && drive.mode == MODE_POSITION) |=> !speed_reached_valid)
        else $error("speed reached offered in position loop");
    a_slot_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && cfg.slot_sel[0] == SEL_NONE) |=> (!slot_out[0] && !slot_used[0]))
        else $error("unmapped slot driven");
    a_hold_level: assert property (@(posedge clk) disable iff (!rst_b)
        !(clk_en && update) |=> $stable(ready_flag) && $stable(speed_reached_flag))
        else $error("status changed without update");

    // With the servo off there is no droop to judge, so in-position must drop.
    a_inp_servo_off: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && !drive.servo_on) |=> !in_position_flag)
        else $error("in-position set while servo off");

    // A slot mapped to the brake interlock must carry the same level as the dedicated output.
    a_slot_brake: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && cfg.slot_sel[1] == SEL_BRAKE) |=>
        (slot_used[1] && (slot_out[1] == !$past(drive.brake_needed))))
        else $error("brake slot does not follow brake need");

    // Speed reached is withdrawn from its slot in the position loop, not just forced low.
    a_slot_speed_pos: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && update && cfg.slot_sel[2] == SEL_SPEED && drive.mode == MODE_POSITION) |=>
        (!slot_used[2] && !slot_out[2]))
        else $error("speed slot offered in position loop");

    // A low clock enable freezes every registered output, whatever the strobe does.
    a_freeze_all: assert property (@(posedge clk) disable iff (!rst_b)
        !clk_en |=> ($stable(in_position_flag) && $stable(brake_interlock_out) && $stable(slot_out)))
        else $error("status changed while clock enable low");

    // ------------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------------
    c_servo_on: cover property (@(posedge clk) disable iff (!rst_b) $rose(in_position_flag));
    c_slot_withdrawn: cover property (@(posedge clk) disable iff (!rst_b) $fell(slot_used[2]));
    c_speed_reach: cover property (@(posedge clk) disable iff (!rst_b) $rose(speed_reached_flag));
    c_brake_drop: cover property (@(posedge clk) disable iff (!rst_b) $fell(brake_interlock_out));
    c_slot_ready: cover property (@(posedge clk) disable iff (!rst_b) slot_used[0] && slot_out[0]);

endmodule

// ==== servo_status_pkg.sv ====
// Package of constants and carrier types for the servo status output block.
package servo_status_pkg;

    // ------------------------------------------------------------------
    // Widths and thresholds
    // ------------------------------------------------------------------
    localparam int DROOP_W = 24;
    localparam int SPEED_W = 16;
    localparam int SPEED_LOW_RPM = 20;               // Commanded speed at or below this keeps speed reached on while the servo is on.
    localparam logic [SPEED_W-1:0] SPEED_LOW_LIMIT = 16'h0014;
    localparam logic [SPEED_W-1:0] SPEED_TOL_RESET = 16'h000a;  // Default approach tolerance.
    localparam logic [DROOP_W-1:0] WINDOW_RESET = 24'h000064;   // Default position window.

    // Output assignment slots: index into the slot map.
    localparam int SLOT_N = 3;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_READY = 2'h1;
    localparam logic [1:0] SEL_BRAKE = 2'h2;
    localparam logic [1:0] SEL_SPEED = 2'h3;

    // Control loop mode.
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h1,
        MODE_SPEED = 2'h2
    } loop_mode_type;

    // Drive state sampled each control cycle.
    typedef struct packed {
        logic servo_on;
        logic able;
        logic brake_needed;
        loop_mode_type mode;
        logic signed [DROOP_W-1:0] droop;
        logic signed [SPEED_W-1:0] speed_meas;
        logic signed [SPEED_W-1:0] speed_cmd;
    } drive_state_type;

    // Configuration held by software.
    typedef struct packed {
        logic [DROOP_W-1:0] position_window_param;
        logic [SPEED_W-1:0] speed_tol;
        logic [SLOT_N-1:0][1:0] slot_sel;
    } status_cfg_type;

endpackage

// ==== brake_unit_model.sv ====
// Behavioural model of an external dynamic brake unit driven by the interlock output.
`timescale 1ns/1ps
module brake_unit_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic brake_interlock_out,
    output logic brake_applied
);
    // ------------------------------------------------------------------
    // Brake contactor
    // ------------------------------------------------------------------
    // The contactor follows the interlock one clock late; a low interlock means brake.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brake_applied <= 1'b1; // Fail safe: brake while the drive is in reset.
        end else begin
            brake_applied <= ~brake_interlock_out;
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking testbench for the servo status output block.
`timescale 1ns/1ps
module testbench;
    import servo_status_pkg::*;
    logic clk = 0, rst_b = 0, clk_en = 1, update = 0, inp, inp_v, rdy, dbi, sar, sar_v, brk;
    drive_state_type d = '0;
    status_cfg_type c = '0;
    logic [SLOT_N-1:0] so, su;
    int bad_count = 0, checks_done = 0, cyc = 0;
    always #10 clk = ~clk;
    servo_status_outputs dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .update(update), .drive(d), .cfg(c),
        .in_position_flag(inp), .in_position_valid(inp_v), .ready_flag(rdy), .brake_interlock_out(dbi),
        .speed_reached_flag(sar), .speed_reached_valid(sar_v), .slot_out(so), .slot_used(su));
    brake_unit_model partner (.clk(clk), .rst_b(rst_b), .brake_interlock_out(dbi), .brake_applied(brk));
    // ------------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------------
    task finish_test;
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One control cycle; results are checked 1 ns after the taken edge.
    task step(input logic en, s, a, b, input loop_mode_type m, input logic signed [23:0] dr,
              input logic signed [15:0] sm, sc);
        @(posedge clk);
        {clk_en, update} <= {en, 1'b1};
        {d.servo_on, d.able, d.brake_needed, d.mode} <= {s, a, b, m};
        {d.droop, d.speed_meas, d.speed_cmd} <= {dr, sm, sc};
        @(posedge clk);
        {clk_en, update} <= 2'b10;
        #1;
    endtask
    task setcfg(input logic [23:0] w, input logic [15:0] t, input logic [5:0] sel);
        @(posedge clk);
        c <= {w, t, sel};
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_position;
        setcfg(24'h000064, 16'h000a, 6'h00);
        step(1, 1, 1, 0, MODE_POSITION, 500, 0, 0);
        chk("inp_on_edge", inp, 1);
        step(1, 1, 1, 0, MODE_POSITION, 500, 0, 0);
        chk("inp_far", inp, 0);
        step(1, 1, 1, 0, MODE_POSITION, -100, 0, 0);
        chk("inp_edge_neg", inp, 1);
        chk("inp_valid", inp_v, 1);
        step(1, 1, 1, 0, MODE_POSITION, 101, 0, 0);
        chk("inp_just_out", inp, 0);
        setcfg(24'h000258, 16'h000a, 6'h00);
        step(1, 1, 1, 0, MODE_POSITION, 500, 0, 0);
        chk("inp_wide", inp, 1);
        step(1, 1, 1, 0, MODE_SPEED, 0, 0, 0);
        chk("inp_valid_spd", inp_v, 0);
    endtask
    task t_speed;
        step(1, 1, 1, 0, MODE_SPEED, 0, 110, 100);
        chk("sa_tol", sar, 1);
        chk("sa_valid", sar_v, 1);
        step(1, 1, 1, 0, MODE_SPEED, 0, 111, 100);
        chk("sa_out_tol", sar, 0);
        step(1, 1, 1, 0, MODE_SPEED, 0, 500, -20);
        chk("sa_low_cmd", sar, 1);
        step(1, 1, 1, 0, MODE_SPEED, 0, 500, 21);
        chk("sa_above_low", sar, 0);
        step(1, 0, 1, 0, MODE_SPEED, 0, 0, 20);
        chk("sa_servo_off", sar, 0);
        step(1, 1, 1, 0, MODE_POSITION, 0, 0, 0);
        chk("sa_valid_pos", sar_v, 0);
    endtask
    task t_ready_brake;
        step(1, 1, 0, 0, MODE_SPEED, 0, 0, 0);
        chk("rd_not_able", rdy, 0);
        step(1, 0, 1, 0, MODE_SPEED, 0, 0, 0);
        chk("rd_servo_off", rdy, 0);
        step(1, 1, 1, 1, MODE_SPEED, 0, 0, 0);
        chk("rd_on", rdy, 1);
        chk("db_brake", dbi, 0);
        @(posedge clk);
        #1;
        chk("ext_brake", brk, 1);
        step(1, 1, 1, 0, MODE_SPEED, 0, 0, 0);
        chk("db_release", dbi, 1);
        step(0, 0, 0, 1, MODE_SPEED, 0, 0, 0);
        chk("hold_rd", rdy, 1);
        chk("hold_db", dbi, 1);
        chk("ext_release", brk, 0);
    endtask
    task t_slots;
        setcfg(24'h000064, 16'h000a, {SEL_SPEED, SEL_BRAKE, SEL_READY});
        step(1, 1, 1, 0, MODE_SPEED, 0, 100, 100);
        chk("slot_used", su, 3'h7);
        chk("slot_out", so, 3'h7);
        step(1, 1, 1, 0, MODE_POSITION, 0, 100, 100);
        chk("slot_used_pos", su, 3'h3);
        chk("slot_out_pos", so, 3'h3);
        setcfg(24'h000064, 16'h000a, 6'h00);
        step(1, 1, 1, 0, MODE_SPEED, 0, 100, 100);
        chk("slot_none", {su, so}, 6'h00);
    endtask
    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test;
        end
    end
    initial begin
        #30;
        chk("reset_out", {inp, inp_v, rdy, dbi, sar, sar_v, so}, 8'h00);
        repeat (4) @(posedge clk);
        rst_b <= 1;
        t_position;
        t_speed;
        t_ready_brake;
        t_slots;
        finish_test;
    end
endmodule
